// *** hw/del_pkg.sv ***
// What this block does
// - Clearing limiter enable stops attack steps only; decay keeps running.
// - Limiter enable is bit 1; when clear, limiter steps use maximum gain.
// - Engine clock enable is bit 0; 0 stops the engine clock, 1 runs it.
// - Engine clock disabled blocks coefficient writes to 0x0E0..0x2BF.
// - Clock enable acts at once; software should use run control instead.
// - Engine control register at offset 0x000B resets to 0x03.
// - Engine writes to levels 0x000C and 0x000D become dB codes.
// - Code 0x00 is -96 dB, each 0x10 adds 6 dB, 0xFF is -0.375 dB.
// - Each level register is 8 bits, read-only, and resets to 0x00.
// - Run control starts and stops the engine only at program start.
package del_pkg;

  // ------------------------------------------------------------
  // Register map (register index, byte address is four times it)
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] REG_ENG_CTRL_IDX = 10'h00B;
  localparam logic [IDX_W-1:0] REG_LEVEL0_IDX = 10'h00C;
  localparam logic [IDX_W-1:0] REG_LEVEL1_IDX = 10'h00D;

  // ------------------------------------------------------------
  // Control fields and reset values
  // ------------------------------------------------------------
  localparam int CTRL_CLK_EN_BIT = 0;
  localparam int CTRL_LIMITER_ATTACK_ENABLE_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h03;
  localparam logic [7:0] CTRL_WR_MASK = 8'h03;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam int LEVEL_NUM = 2;

  // ------------------------------------------------------------
  // Parameter memory biquad coefficient window
  // ------------------------------------------------------------
  localparam int PM_ADDR_W = 10;
  localparam int PM_DATA_W = 32;
  localparam logic [PM_ADDR_W-1:0] PM_BIQ_LO = 10'h0E0;
  localparam logic [PM_ADDR_W-1:0] PM_BIQ_HI = 10'h2BF;

  // ------------------------------------------------------------
  // Limiter gain and level conversion
  // ------------------------------------------------------------
  localparam int GAIN_W = 24;
  localparam logic [GAIN_W-1:0] LIM_MAX_GAIN = 24'h800000;
  localparam int LVL_W = 24;
  localparam int DB_FRAC_W = 4;
  localparam logic [4:0] DB_MIN_MSB = 5'h08;
  localparam logic [7:0] DB_CODE_FLOOR = 8'h00;

endpackage

// *** hw/del_db_conv.sv ***
`timescale 1ns/1ps
`default_nettype none
// Linear magnitude to 8-bit dB code, 0.375 dB per code step
module del_db_conv (
  input wire logic [del_pkg::LVL_W-1:0] mag,
  output logic [7:0] code
);
  import del_pkg::*;

  logic [4:0] msb;
  logic [LVL_W-1:0] norm;
  logic [DB_FRAC_W-1:0] frac;

  // ------------------------------------------------------------
  // Leading one search and mantissa
  // ------------------------------------------------------------
  // Octave from the leading one, four mantissa bits as fraction
  always_comb begin
    msb = 5'h00;
    for (int i = 0; i < LVL_W; i++) begin
      if (mag[i]) begin
        msb = 5'(i);
      end
    end
    norm = mag << (5'd23 - msb);
    frac = norm[LVL_W-2 -: DB_FRAC_W];
    if (msb < DB_MIN_MSB) begin
      code = DB_CODE_FLOOR;
    end else begin
      code = {4'(msb - DB_MIN_MSB), frac};
    end
  end

endmodule
`default_nettype wire

// *** hw/del_engine_ctrl.sv ***
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module del_engine_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [del_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Engine clock and run control
  input wire logic core_run,
  input wire logic prog_start,
  output logic engine_clk_en,
  output logic engine_run,
  // Limiter
  input wire logic lim_attack_req,
  input wire logic lim_decay_req,
  input wire logic [del_pkg::GAIN_W-1:0] lim_gain_in,
  output logic limiter_attack_enable,
  output logic lim_attack_go,
  output logic lim_decay_go,
  output logic [del_pkg::GAIN_W-1:0] lim_gain_out,
  // Engine writes to level registers
  input wire logic eng_lvl_wr,
  input wire logic eng_lvl_sel,
  input wire logic [del_pkg::LVL_W-1:0] eng_lvl_data,
  // Parameter memory write path
  input wire logic pm_in_wr,
  input wire logic [del_pkg::PM_ADDR_W-1:0] pm_in_addr,
  input wire logic [del_pkg::PM_DATA_W-1:0] pm_in_data,
  output logic pm_out_wr,
  output logic [del_pkg::PM_ADDR_W-1:0] pm_out_addr,
  output logic [del_pkg::PM_DATA_W-1:0] pm_out_data,
  output logic pm_out_blocked
);
  import del_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] level_reg [LEVEL_NUM];
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic run_reg;
  logic clk_en_reg;
  logic limiter_attack_enable_reg;
  logic attack_go_reg;
  logic decay_go_reg;
  logic [GAIN_W-1:0] gain_reg;
  logic pm_wr_reg;
  logic [PM_ADDR_W-1:0] pm_addr_reg;
  logic [PM_DATA_W-1:0] pm_data_reg;
  logic pm_blk_reg;
  logic [7:0] conv_code;

  wire [IDX_W-1:0] bus_idx = avs_address[ADDR_W-1:2];
  wire bus_aligned = (avs_address[1:0] == 2'b00);
  wire bus_req = avs_read | avs_write;
  wire bus_take = bus_req & ~wait_reg;
  wire hit_ctrl = bus_aligned & (bus_idx == REG_ENG_CTRL_IDX);
  wire hit_lvl0 = bus_aligned & (bus_idx == REG_LEVEL0_IDX);
  wire hit_lvl1 = bus_aligned & (bus_idx == REG_LEVEL1_IDX);
  wire ctrl_wr = bus_take & avs_write & hit_ctrl & avs_byteenable[0];
  wire clk_en_bit = ctrl_reg[CTRL_CLK_EN_BIT];
  wire limiter_attack_enable_bit = ctrl_reg[CTRL_LIMITER_ATTACK_ENABLE_BIT];

  // ------------------------------------------------------------
  // Bus handshake and read decode
  // ------------------------------------------------------------
  // Every request answers on the second edge; unmapped reads give zero
  assign rdata_next = hit_ctrl ? {24'h000000, ctrl_reg} :
                      hit_lvl0 ? {24'h000000, level_reg[0]} :
                      hit_lvl1 ? {24'h000000, level_reg[1]} :
                      32'h00000000;

  // Only reserved-free bits of the control byte are writable
  assign ctrl_next = (ctrl_reg & ~CTRL_WR_MASK) |
                     (avs_writedata[7:0] & CTRL_WR_MASK);

  // Wait state drops for exactly one cycle per request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (avs_read & wait_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ------------------------------------------------------------
  // Engine control register
  // ------------------------------------------------------------
  // Host write lands on the edge at which waitrequest is sampled low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Enable mirrors take the written value on the write edge
  wire clk_en_next = ctrl_wr ? ctrl_next[CTRL_CLK_EN_BIT] : clk_en_bit;
  wire limiter_attack_enable_next = ctrl_wr ? ctrl_next[CTRL_LIMITER_ATTACK_ENABLE_BIT] : limiter_attack_enable_bit;

  // Clock enable follows the bit immediately, even mid program
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_en_reg <= CTRL_RESET[CTRL_CLK_EN_BIT];
      limiter_attack_enable_reg <= CTRL_RESET[CTRL_LIMITER_ATTACK_ENABLE_BIT];
    end else begin
      clk_en_reg <= clk_en_next;
      limiter_attack_enable_reg <= limiter_attack_enable_next;
    end
  end

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  // Run level is sampled only at the start of a program pass
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_reg <= 1'b0;
    end else if (prog_start) begin
      run_reg <= core_run;
    end
  end

  // ------------------------------------------------------------
  // Limiter gating
  // ------------------------------------------------------------
  // Attack needs the enable, decay never waits for it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      attack_go_reg <= 1'b0;
      decay_go_reg <= 1'b0;
      gain_reg <= LIM_MAX_GAIN;
    end else begin
      attack_go_reg <= lim_attack_req & limiter_attack_enable_bit;
      decay_go_reg <= lim_decay_req;
      gain_reg <= limiter_attack_enable_bit ? lim_gain_in : LIM_MAX_GAIN;
    end
  end

  // ------------------------------------------------------------
  // Parameter memory write gate
  // ------------------------------------------------------------
  wire pm_in_biq = (pm_in_addr >= PM_BIQ_LO) & (pm_in_addr <= PM_BIQ_HI);
  wire pm_block = pm_in_wr & pm_in_biq & ~clk_en_bit;

  // Coefficient writes pass only while the engine clock runs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pm_wr_reg <= 1'b0;
      pm_blk_reg <= 1'b0;
      pm_addr_reg <= '0;
      pm_data_reg <= '0;
    end else begin
      pm_wr_reg <= pm_in_wr & ~pm_block;
      pm_blk_reg <= pm_block;
      if (pm_in_wr) begin
        pm_addr_reg <= pm_in_addr;
        pm_data_reg <= pm_in_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Level registers
  // ------------------------------------------------------------
  del_db_conv u_conv (
    .mag(eng_lvl_data),
    .code(conv_code)
  );

  // Only the engine loads a level; host writes never reach here
  for (genvar g = 0; g < LEVEL_NUM; g++) begin : g_level
    wire load = eng_lvl_wr & (eng_lvl_sel == 1'(g));
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        level_reg[g] <= LEVEL_RESET;
      end else if (load) begin
        level_reg[g] <= conv_code;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign engine_clk_en = clk_en_reg;
  assign engine_run = run_reg;
  assign limiter_attack_enable = limiter_attack_enable_reg;
  assign lim_attack_go = attack_go_reg;
  assign lim_decay_go = decay_go_reg;
  assign lim_gain_out = gain_reg;
  assign pm_out_wr = pm_wr_reg;
  assign pm_out_addr = pm_addr_reg;
  assign pm_out_data = pm_data_reg;
  assign pm_out_blocked = pm_blk_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  wire lvl_host_wr = bus_take & avs_write & (hit_lvl0 | hit_lvl1);

  AST_CTRL_RESET: assert property ($past(rst) |->
    ctrl_reg == CTRL_RESET)
    else $error("control register not 0x03 after reset");

  AST_LEVEL_RESET: assert property ($past(rst) |->
    level_reg[0] == LEVEL_RESET && level_reg[1] == LEVEL_RESET)
    else $error("level registers not zero after reset");

  AST_CLK_EN_NOW: assert property (ctrl_wr |=>
    engine_clk_en == $past(avs_writedata[0]))
    else $error("engine clock enable did not follow write");

  AST_CLK_EN_HOLD: assert property (!ctrl_wr |=>
    $stable(engine_clk_en))
    else $error("engine clock enable moved without a write");

  AST_PM_BLOCKED: assert property (pm_in_wr && !engine_clk_en &&
    pm_in_addr >= PM_BIQ_LO && pm_in_addr <= PM_BIQ_HI |=>
    !pm_out_wr && pm_out_blocked)
    else $error("coefficient write passed with clock disabled");

  AST_PM_PASS: assert property (pm_in_wr && engine_clk_en |=>
    pm_out_wr && pm_out_addr == $past(pm_in_addr))
    else $error("parameter write lost with clock enabled");

  AST_ATTACK_OFF: assert property (lim_attack_req &&
    !limiter_attack_enable |=> !lim_attack_go)
    else $error("attack step passed while limiter disabled");

  AST_DECAY_ON: assert property (lim_decay_req |=> lim_decay_go)
    else $error("decay step dropped");

  AST_MAX_GAIN: assert property (!limiter_attack_enable && !ctrl_wr
    |=> lim_gain_out == LIM_MAX_GAIN)
    else $error("gain not at maximum while limiter disabled");

  AST_RUN_AT_START: assert property (!prog_start |=>
    $stable(engine_run))
    else $error("run state changed mid program");

  AST_LEVEL_RO: assert property (lvl_host_wr && !eng_lvl_wr |=>
    $stable(level_reg[0]) && $stable(level_reg[1]))
    else $error("host write changed a level register");

  AST_CONV_TOP: assert property (eng_lvl_wr && !eng_lvl_sel &&
    eng_lvl_data == 24'h800000 |=> level_reg[0] == 8'hF0)
    else $error("full scale octave not coded as 0xF0");

  AST_CONV_MAX: assert property (eng_lvl_wr && eng_lvl_sel &&
    eng_lvl_data == 24'hFFFFFF |=> level_reg[1] == 8'hFF)
    else $error("largest magnitude not coded as 0xFF");

  AST_CONV_FLOOR: assert property (eng_lvl_wr &&
    eng_lvl_data < 24'h000100 |=> level_reg[$past(eng_lvl_sel)] == 8'h00)
    else $error("small magnitude not coded as -96 dB");

  AST_BUS_ANSWER: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle later");

  // ------------------------------------------------------------
  // Assertions on enables, gating, levels and read data
  // ------------------------------------------------------------
  AST_LIMITER_ATTACK_ENABLE_NOW: assert property (ctrl_wr |=>
    limiter_attack_enable == $past(avs_writedata[CTRL_LIMITER_ATTACK_ENABLE_BIT]))
    else $error("limiter enable did not follow write");

  AST_LIMITER_ATTACK_ENABLE_HOLD: assert property (!ctrl_wr |=>
    $stable(limiter_attack_enable))
    else $error("limiter enable moved without a write");

  AST_CTRL_LANE: assert property (bus_take && avs_write && hit_ctrl &&
    !avs_byteenable[0] |=> $stable(ctrl_reg))
    else $error("control write without lane 0 took effect");

  AST_ATTACK_ON: assert property (lim_attack_req &&
    limiter_attack_enable |=> lim_attack_go)
    else $error("attack step lost while limiter enabled");

  AST_GAIN_PASS: assert property (limiter_attack_enable |=>
    lim_gain_out == $past(lim_gain_in))
    else $error("limiter gain not passed while enabled");

  AST_RUN_TAKE: assert property (prog_start |=>
    engine_run == $past(core_run))
    else $error("run level not taken at program start");

  AST_PM_OUTSIDE: assert property (pm_in_wr &&
    (pm_in_addr < PM_BIQ_LO || pm_in_addr > PM_BIQ_HI) |=>
    pm_out_wr && !pm_out_blocked)
    else $error("write outside coefficient window not passed");

  AST_PM_IDLE: assert property (!pm_in_wr |=>
    !pm_out_wr && !pm_out_blocked)
    else $error("parameter write output without a request");

  AST_LEVEL_IDLE: assert property (!eng_lvl_wr |=>
    $stable(level_reg[0]) && $stable(level_reg[1]))
    else $error("level register changed without an engine write");

  AST_LEVEL_KEEP0: assert property (eng_lvl_wr && eng_lvl_sel |=>
    $stable(level_reg[0]))
    else $error("write to level 1 changed level 0");

  AST_LEVEL_KEEP1: assert property (eng_lvl_wr && !eng_lvl_sel |=>
    $stable(level_reg[1]))
    else $error("write to level 0 changed level 1");

  AST_CONV_STEP: assert property (eng_lvl_wr && !eng_lvl_sel &&
    eng_lvl_data == 24'h000200 |=> level_reg[0] == 8'h10)
    else $error("one octave above the floor not coded as 0x10");

  AST_READ_CTRL: assert property (avs_read && avs_waitrequest &&
    hit_ctrl |=> avs_readdata == {24'h000000, $past(ctrl_reg)})
    else $error("control read data wrong");

  AST_READ_LVL0: assert property (avs_read && avs_waitrequest &&
    hit_lvl0 |=> avs_readdata == {24'h000000, $past(level_reg[0])})
    else $error("level 0 read data wrong");

  AST_READ_LVL1: assert property (avs_read && avs_waitrequest &&
    hit_lvl1 |=> avs_readdata == {24'h000000, $past(level_reg[1])})
    else $error("level 1 read data wrong");

  AST_BUS_WRITE: assert property (avs_write && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus write answer not one cycle later");

endmodule
`default_nettype wire

// *** dv/del_engine_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module del_engine_ctrl_bench;
  import del_pkg::*;
  // ----------------------------------------------------------
  // Addresses, stimulus table and signals
  // ----------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CTRL = {REG_ENG_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_LV0 = {REG_LEVEL0_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_LV1 = {REG_LEVEL1_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_NONE = 12'h040;
  logic [23:0] tbl [8] = '{24'h000000, 24'h0000FF, 24'h000100, 24'h000180,
    24'h000200, 24'h001234, 24'h800000, 24'hFFFFFF};
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic core_run, prog_start, engine_clk_en, engine_run;
  logic lim_attack_req, lim_decay_req, limiter_attack_enable;
  logic lim_attack_go, lim_decay_go, eng_lvl_wr, eng_lvl_sel;
  logic [GAIN_W-1:0] lim_gain_in, lim_gain_out;
  logic [LVL_W-1:0] eng_lvl_data;
  logic pm_in_wr, pm_out_wr, pm_out_blocked;
  logic [PM_ADDR_W-1:0] pm_in_addr, pm_out_addr;
  logic [PM_DATA_W-1:0] pm_in_data, pm_out_data;
  int n_fail;
  int checked;

  // Device under test, every port driven or watched
  del_engine_ctrl u_dut (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_run(core_run), .prog_start(prog_start),
    .engine_clk_en(engine_clk_en), .engine_run(engine_run),
    .lim_attack_req(lim_attack_req), .lim_decay_req(lim_decay_req),
    .lim_gain_in(lim_gain_in), .limiter_attack_enable(limiter_attack_enable),
    .lim_attack_go(lim_attack_go), .lim_decay_go(lim_decay_go),
    .lim_gain_out(lim_gain_out), .eng_lvl_wr(eng_lvl_wr),
    .eng_lvl_sel(eng_lvl_sel), .eng_lvl_data(eng_lvl_data),
    .pm_in_wr(pm_in_wr), .pm_in_addr(pm_in_addr), .pm_in_data(pm_in_data),
    .pm_out_wr(pm_out_wr), .pm_out_addr(pm_out_addr),
    .pm_out_data(pm_out_data), .pm_out_blocked(pm_out_blocked));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------
  // Checking, bus and port tasks
  // ----------------------------------------------------------
  task automatic close_out();
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rdata);
    int n;
    @(posedge ref_clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] dummy;
    bus(1'b0, a, d, be, dummy);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [31:0] got;
    bus(1'b1, a, 32'h00000000, 4'hF, got);
    cmp_vec(got, {24'h000000, exp}, "register read");
  endtask

  // Engine-side level write, one cycle pulse
  task automatic lvl(input logic sel, input logic [23:0] d);
    @(posedge ref_clk);
    eng_lvl_wr <= 1'b1;
    eng_lvl_sel <= sel;
    eng_lvl_data <= d;
    @(posedge ref_clk);
    eng_lvl_wr <= 1'b0;
  endtask

  // Parameter memory write and its forwarded or dropped result
  task automatic pm(input logic [9:0] a, input logic blk);
    @(posedge ref_clk);
    pm_in_wr <= 1'b1;
    pm_in_addr <= a;
    pm_in_data <= {22'h000000, a};
    @(posedge ref_clk);
    pm_in_wr <= 1'b0;
    @(negedge ref_clk);
    cmp_bit(pm_out_blocked, blk, "pm dropped");
    cmp_bit(pm_out_wr, !blk, "pm forwarded");
    if (!blk) begin
      cmp_vec(pm_out_data, {22'h000000, a}, "pm data");
      cmp_vec({22'h000000, pm_out_addr}, {22'h000000, a}, "pm addr");
    end
  endtask

  task automatic chk_reset();
    @(negedge ref_clk);
    cmp_bit(engine_clk_en, 1'b1, "clock enable");
    cmp_bit(limiter_attack_enable, 1'b1, "limiter enable");
    rd_chk(A_CTRL, 8'h03);
    rd_chk(A_LV0, 8'h00);
    rd_chk(A_LV1, 8'h00);
  endtask

  // Level code from magnitude: octave index above, four mantissa bits below
  function automatic logic [7:0] exp_code(input logic [23:0] d);
    int p;
    logic [23:0] s;
    p = -1;
    for (int i = 0; i < 24; i++) if (d[i]) p = i;
    if (p < 8) return 8'h00;
    s = d << (23 - p);
    return {4'(p - 8), s[22:19]};
  endfunction

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {rst, avs_read, avs_write, core_run, prog_start} = 5'h10;
    {lim_attack_req, lim_decay_req, eng_lvl_wr, eng_lvl_sel, pm_in_wr} = 5'h00;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    {lim_gain_in, eng_lvl_data, pm_in_addr, pm_in_data} = '0;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    chk_reset();
    // Host cannot write level registers; unmapped place reads zero
    wr(A_LV0, 32'h000000FF, 4'hF);
    wr(A_LV1, 32'h000000FF, 4'hF);
    wr(A_NONE, 32'h000000FF, 4'hF);
    rd_chk(A_LV0, 8'h00);
    rd_chk(A_LV1, 8'h00);
    rd_chk(A_NONE, 8'h00);
    rd_chk(A_CTRL + 12'h001, 8'h00);
    rd_chk(A_CTRL, 8'h03);
    // Engine writes converted to level codes, both registers
    for (int i = 0; i < 8; i++) begin
      lvl(i[0], tbl[i]);
      rd_chk(i[0] ? A_LV1 : A_LV0, exp_code(tbl[i]));
    end
    rd_chk(A_LV0, 8'hF0);
    rd_chk(A_LV1, 8'hFF);
    lvl(1'b1, 24'h0000FF);
    rd_chk(A_LV1, 8'h00);
    // Clear both enables; upper bits read back zero
    wr(A_CTRL, 32'hFFFFFFFC, 4'hF);
    @(negedge ref_clk);
    cmp_bit(engine_clk_en, 1'b0, "clock enable");
    cmp_bit(limiter_attack_enable, 1'b0, "limiter enable");
    wr(A_CTRL, 32'h00000003, 4'hE);
    rd_chk(A_CTRL, 8'h00);
    // Coefficient window edges with the engine clock off, then on
    pm(10'h0DF, 1'b0);
    pm(10'h0E0, 1'b1);
    pm(10'h2BF, 1'b1);
    pm(10'h2C0, 1'b0);
    wr(A_CTRL, 32'h00000001, 4'h1);
    pm(10'h0E0, 1'b0);
    // Limiter disabled then enabled; decay always passes
    for (int e = 0; e < 2; e++) begin
      wr(A_CTRL, {30'h00000000, e[0], 1'b1}, 4'h1);
      @(posedge ref_clk);
      lim_attack_req <= 1'b1;
      lim_decay_req <= 1'b1;
      lim_gain_in <= 24'h123456;
      @(posedge ref_clk);
      @(negedge ref_clk);
      cmp_bit(lim_attack_go, e[0], "attack step");
      cmp_bit(lim_decay_go, 1'b1, "decay step");
      cmp_vec(lim_gain_out, e[0] ? 24'h123456 : LIM_MAX_GAIN, "gain");
      @(posedge ref_clk);
      lim_attack_req <= 1'b0;
      lim_decay_req <= 1'b0;
    end
    // Run level is taken only at program start
    @(posedge ref_clk);
    core_run <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_bit(engine_run, 1'b0, "run early");
    @(posedge ref_clk);
    prog_start <= 1'b1;
    @(posedge ref_clk);
    prog_start <= 1'b0;
    @(negedge ref_clk);
    cmp_bit(engine_run, 1'b1, "run at start");
    // Clock gate follows the bit at once, mid pass
    wr(A_CTRL, 32'h00000002, 4'h1);
    @(negedge ref_clk);
    cmp_bit(engine_clk_en, 1'b0, "gate mid pass");
    @(posedge ref_clk);
    core_run <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_bit(engine_run, 1'b1, "stop waits");
    // Second reset in mid-run restores every reset value
    lvl(1'b0, 24'h800000);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    chk_reset();
    cmp_bit(engine_run, 1'b0, "run after reset");
    close_out();
  end
endmodule
`default_nettype wire
